// ===== pgpc_pad_model.sv
// pgpc_pad_model: board side of the pads, with pulls and external drivers
`timescale 1ns/10ps
module pgpc_pad_model (
	// clock
	input wire logic ref_clk,
	// pad controls from the block
	input wire logic [15:0] pad_out,
	input wire logic [15:0] pad_oe,
	input wire logic [15:0] pull_up_en,
	input wire logic [15:0] pull_down_en,
	// external driver per pin
	input wire logic [15:0] ext_en,
	input wire logic [15:0] ext_val,
	// resolved pad level
	output logic [15:0] pad_in
);
	logic [15:0] last_q = '0; // last resolved level
	// remember levels so a floating pin never holds its old value
	always_ff @(posedge ref_clk)
		last_q <= pad_in;
	// block drive wins, then board driver, then pulls, else float
	always_comb
		for (int i = 0; i < 16; i++)
			if (pad_oe[i])
				pad_in[i] = pad_out[i];
			else if (ext_en[i])
				pad_in[i] = ext_val[i];
			else if (pull_up_en[i])
				pad_in[i] = 1'b1;
			else if (pull_down_en[i])
				pad_in[i] = 1'b0;
			else
				pad_in[i] = ~last_q[i];
endmodule : pgpc_pad_model

// ===== pgpc_pkg.sv
// pgpc_pkg: constants and types for the pin configuration block
// Overview of operation
// RULE_01 - direction bit picks input or output function
// RULE_02 - four-bit function select, resets to zero
// RULE_03 - polarity zero inverts inputs and outputs
// RULE_04 - drive type picks push-pull or open-drain
// RULE_05 - pull field: none, down, up, reserved
// RULE_06 - software enables pull-up for bare open-drain
// RULE_07 - pad disable tri-states and disconnects pin
// RULE_08 - tri-stated pin drops both pulls
// RULE_09 - edge mode: both edges or polarity edge
// RULE_10 - supply select exists on pins 1-12
// RULE_11 - function 9h drives converter slew done
// RULE_12 - functions Ah, Bh drive sequenced enables
// RULE_13 - function Ch drives system supply ok
// RULE_14 - function Dh power good in ON/SLEEP only
// RULE_15 - function Eh drives converter-synchronous clock
// RULE_16 - function Fh aux reset in OFF, configurable SLEEP
// RULE_17 - function 0h output drives written level
// RULE_18 - undefined control bits read zero
package pgpc_pkg;
	localparam int NPIN = 16;
	localparam int NDOM = 12;
	localparam int AW = 18;
	// register indexes; byte address is four times the index
	localparam logic [15:0] IDX_CTRL0 = 16'h4038;
	localparam logic [15:0] IDX_CTRL15 = 16'h4047;
	localparam logic [15:0] IDX_LEVEL = 16'h400C;
	localparam logic [15:0] IDX_IRQ_STS = 16'h4050;
	localparam logic [15:0] IDX_IRQ_CLR = 16'h4051;
	localparam logic [15:0] IDX_IRQ_EN = 16'h4052;
	localparam logic [15:0] IDX_AUX_CFG = 16'h4053;
	// control field positions
	localparam int B_DIR = 15;
	localparam int B_PULL_HI = 14;
	localparam int B_PULL_LO = 13;
	localparam int B_MODE = 12;
	localparam int B_DOM = 11;
	localparam int B_POL = 10;
	localparam int B_OD = 9;
	localparam int B_EN = 7;
	localparam int B_FN_HI = 3;
	// reset value and writable bits of a control register
	localparam logic [15:0] CTRL_RST = 16'hA400;
	localparam logic [15:0] CTRL_WMASK = 16'hFE8F;
	localparam logic [1:0] PULL_DOWN = 2'h1;
	localparam logic [1:0] PULL_UP = 2'h2;
	// output function codes
	localparam logic [3:0] FN_GPIO = 4'h0;
	localparam logic [3:0] FN_SLEW = 4'h9;
	localparam logic [3:0] FN_EXT1 = 4'hA;
	localparam logic [3:0] FN_EXT2 = 4'hB;
	localparam logic [3:0] FN_SUPPLY_OK = 4'hC;
	localparam logic [3:0] FN_PGOOD = 4'hD;
	localparam logic [3:0] FN_CLK = 4'hE;
	localparam logic [3:0] FN_AUXRST = 4'hF;
	typedef enum logic [1:0] {PWR_OFF, PWR_ON, PWR_SLEEP} pgpc_pwr_e;
	// internal status signals offered to the pins
	typedef struct packed {
		logic slew_done_dc2;
		logic [1:0] ext_enable;
		logic system_supply_ok;
		logic converters_power_good;
		logic conv_clk_2mhz;
		pgpc_pwr_e power_state;
	} pgpc_status_s;
	// whole state of the block
	typedef struct packed {
		logic [NPIN-1:0][15:0] ctrl;
		logic [NPIN-1:0] lvl;
		logic [NPIN-1:0] sync1;
		logic [NPIN-1:0] sync2;
		logic [NPIN-1:0] in_prev;
		logic [NPIN-1:0] irq_sts;
		logic [NPIN-1:0] irq_en;
		logic aux_sleep;
		logic ack;
		logic [31:0] rdata;
		logic [NPIN-1:0] pad_out;
		logic [NPIN-1:0] pad_oe;
		logic [NPIN-1:0] pu;
		logic [NPIN-1:0] pd;
	} pgpc_state_s;
endpackage : pgpc_pkg

// ===== pgpc_top.sv
// pgpc_top: sixteen-pin configuration, output mux and register slave
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/10ps
module pgpc_top (
	// clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// avalon-mm slave, byte address
	input wire logic [pgpc_pkg::AW-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// pads
	input wire logic [pgpc_pkg::NPIN-1:0] pad_in,
	output logic [pgpc_pkg::NPIN-1:0] pad_out,
	output logic [pgpc_pkg::NPIN-1:0] pad_oe,
	output logic [pgpc_pkg::NPIN-1:0] pull_up_en,
	output logic [pgpc_pkg::NPIN-1:0] pull_down_en,
	output logic [pgpc_pkg::NDOM-1:0] supply_sel,
	// internal status sources, same clock
	input wire pgpc_pkg::pgpc_status_s status,
	// to the rest of the chip
	output logic [pgpc_pkg::NPIN-1:0] pin_in_level,
	output logic irq
);
	import pgpc_pkg::*;

	pgpc_state_s s_q; // registered state
	pgpc_state_s s_d; // next state
	logic [15:0] idx; // word index of the access
	logic mapped; // word aligned
	logic [15:0] wmask; // byte lanes as bit mask

	// output source for one pin, before polarity
	function automatic logic out_src(input logic [3:0] fn, input logic lvl,
		input pgpc_status_s st, input logic aux_sleep);
		logic on_or_sleep;
		on_or_sleep = (st.power_state == PWR_ON) || (st.power_state == PWR_SLEEP);
		case (fn)
			FN_GPIO: out_src = lvl; // RULE_17
			FN_SLEW: out_src = st.slew_done_dc2; // RULE_11
			FN_EXT1: out_src = st.ext_enable[0]; // RULE_12
			FN_EXT2: out_src = st.ext_enable[1]; // RULE_12
			FN_SUPPLY_OK: out_src = st.system_supply_ok; // RULE_13
			// gated here so a stale good never leaks in OFF
			FN_PGOOD: out_src = st.converters_power_good && on_or_sleep; // RULE_14
			FN_CLK: out_src = st.conv_clk_2mhz; // RULE_15
			FN_AUXRST: out_src = (st.power_state == PWR_OFF) ||
				((st.power_state == PWR_SLEEP) && aux_sleep); // RULE_16
			// other output functions live elsewhere, source held low before polarity
			default: out_src = 1'b0;
		endcase
	endfunction : out_src

	// read decode, reserved bits already zero in storage
	function automatic logic [31:0] rd_mux(input pgpc_state_s s, input logic [15:0] i,
		input logic ok);
		rd_mux = 32'h0000_0000;
		if (!ok)
		begin
			rd_mux = 32'h0000_0000;
		end
		else if (i >= IDX_CTRL0 && i <= IDX_CTRL15)
		begin
			rd_mux = {16'h0000, s.ctrl[4'(i - IDX_CTRL0)]}; // RULE_18
		end
		else if (i == IDX_LEVEL)
		begin
			rd_mux = {16'h0000, s.in_prev};
		end
		else if (i == IDX_IRQ_STS)
		begin
			rd_mux = {16'h0000, s.irq_sts};
		end
		else if (i == IDX_IRQ_EN)
		begin
			rd_mux = {16'h0000, s.irq_en};
		end
		else if (i == IDX_AUX_CFG)
		begin
			rd_mux = {31'h0000_0000, s.aux_sleep};
		end
	endfunction : rd_mux

	// address split and lane mask
	assign idx = avs_address[AW-1:2];
	assign mapped = (avs_address[1:0] == 2'h0);
	assign wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

	// one wait cycle per access: accepted on the second edge after request
	assign avs_waitrequest = (avs_read || avs_write) && !s_q.ack;
	assign avs_readdata = s_q.rdata;

	// pad side straight from flip-flops
	assign pad_out = s_q.pad_out;
	assign pad_oe = s_q.pad_oe;
	assign pull_up_en = s_q.pu;
	assign pull_down_en = s_q.pd;
	assign pin_in_level = s_q.in_prev;
	assign irq = |(s_q.irq_sts & s_q.irq_en);

	// supply select only exists on the first twelve pins
	genvar g;
	generate
		for (g = 0; g < NDOM; g++)
		begin : g_dom
			assign supply_sel[g] = s_q.ctrl[g][B_DOM]; // RULE_10
		end
	endgenerate

	// next state: pins, interrupt flags and bus
	always_comb
	begin
		logic [15:0] c; // control word of pin
		logic inval; // logical input level
		logic drv; // output level after polarity
		logic ev; // interrupt event
		logic [NPIN-1:0] clr; // clear bits from bus
		c = 16'h0000;
		inval = 1'b0;
		drv = 1'b0;
		ev = 1'b0;
		clr = '0;
		s_d = s_q;
		// two-flop pad synchroniser
		s_d.sync1 = pad_in;
		s_d.sync2 = s_q.sync1;
		// bus answer registered at the first edge, writes at the accepting edge
		s_d.ack = (avs_read || avs_write) && !s_q.ack;
		if ((avs_read || avs_write) && !s_q.ack)
		begin
			s_d.rdata = avs_read ? rd_mux(s_q, idx, mapped) : 32'h0000_0000;
		end
		if (avs_write && s_q.ack && mapped)
		begin
			if (idx >= IDX_CTRL0 && idx <= IDX_CTRL15)
			begin
				// undefined bits never stored
				s_d.ctrl[4'(idx - IDX_CTRL0)] = (s_q.ctrl[4'(idx - IDX_CTRL0)] & ~wmask) |
					(avs_writedata[15:0] & wmask & CTRL_WMASK); // RULE_18
			end
			else if (idx == IDX_LEVEL)
			begin
				s_d.lvl = (s_q.lvl & ~wmask) | (avs_writedata[15:0] & wmask); // RULE_17
			end
			else if (idx == IDX_IRQ_CLR)
			begin
				clr = avs_writedata[15:0] & wmask;
			end
			else if (idx == IDX_IRQ_EN)
			begin
				s_d.irq_en = (s_q.irq_en & ~wmask) | (avs_writedata[15:0] & wmask);
			end
			else if (idx == IDX_AUX_CFG)
			begin
				if (avs_byteenable[0])
				begin
					s_d.aux_sleep = avs_writedata[0];
				end
			end
		end
		// per-pin input, interrupt and pad drive
		for (int i = 0; i < NPIN; i++)
		begin
			c = s_q.ctrl[i];
			// disabled pad is cut off from the pin logic
			inval = c[B_EN] && (s_q.sync2[i] ~^ c[B_POL]); // RULE_07 RULE_03
			s_d.in_prev[i] = inval;
			// polarity already folded in, so rising is the active edge
			if (c[B_MODE])
			begin
				ev = inval != s_q.in_prev[i]; // RULE_09
			end
			else
			begin
				ev = inval && !s_q.in_prev[i]; // RULE_09
			end
			ev = ev && c[B_DIR] && c[B_EN]; // RULE_01
			// a new event beats a clear in the same cycle
			s_d.irq_sts[i] = (s_q.irq_sts[i] && !clr[i]) || ev;
			drv = out_src(c[B_FN_HI:0], s_q.lvl[i], status, s_q.aux_sleep) ~^
				c[B_POL]; // RULE_02 RULE_03
			if (!c[B_EN] || c[B_DIR])
			begin
				// tri-state or input: never drive
				s_d.pad_oe[i] = 1'b0; // RULE_07 RULE_01
				s_d.pad_out[i] = 1'b0;
			end
			else if (c[B_OD])
			begin
				// open drain only pulls low
				s_d.pad_oe[i] = !drv; // RULE_04
				s_d.pad_out[i] = 1'b0;
			end
			else
			begin
				s_d.pad_oe[i] = 1'b1; // RULE_04
				s_d.pad_out[i] = drv;
			end
			// pulls off while tri-stated; code 11 gives none
			s_d.pu[i] = c[B_EN] && (c[B_PULL_HI:B_PULL_LO] == PULL_UP); // RULE_05 RULE_08
			s_d.pd[i] = c[B_EN] && (c[B_PULL_HI:B_PULL_LO] == PULL_DOWN); // RULE_05 RULE_08
		end
	end

	// state register, synchronous reset
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			s_q <= '0;
			for (int k = 0; k < NPIN; k++)
			begin
				s_q.ctrl[k] <= CTRL_RST; // RULE_01 RULE_02
			end
		end
		else
		begin
			s_q <= s_d;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (srst);

	// request seen for the first time
	sequence s_req_new;
		(avs_read || avs_write) && !s_q.ack;
	endsequence
	// slave held off exactly one cycle
	sequence s_one_wait;
		avs_waitrequest ##1 !avs_waitrequest;
	endsequence
	a_bus_wait_once: assert property (s_req_new |-> s_one_wait)
		else $error("bus answer not after one wait cycle");

	// per-pin checks
	generate
		for (g = 0; g < NPIN; g++)
		begin : g_chk
			// logical input rose while the pin was an enabled input
			sequence s_in_rise;
				!s_q.in_prev[g] && s_q.ctrl[g][B_DIR] && s_q.ctrl[g][B_EN] ##1 s_q.in_prev[g];
			endsequence
			a_dir_no_drive: assert property (pad_oe[g] |-> // RULE_01
				!$past(s_q.ctrl[g][B_DIR]) && $past(s_q.ctrl[g][B_EN]))
				else $error("pad driven while input or disabled");
			a_tristate_quiet: assert property (!s_q.ctrl[g][B_EN] |=> // RULE_07
				!pad_oe[g] && !pin_in_level[g])
				else $error("disabled pad not isolated");
			a_pull_off: assert property (!s_q.ctrl[g][B_EN] |=> // RULE_08
				!pull_up_en[g] && !pull_down_en[g])
				else $error("pull left on while tri-stated");
			a_pull_up_sel: assert property (s_q.ctrl[g][B_EN] && // RULE_05
				s_q.ctrl[g][B_PULL_HI:B_PULL_LO] == PULL_UP |=>
				pull_up_en[g] && !pull_down_en[g])
				else $error("pull-up select wrong");
			a_od_never_high: assert property (s_q.ctrl[g][B_OD] |=> // RULE_04
				!pad_out[g])
				else $error("open drain drove high");
			a_gpio_level: assert property (s_q.ctrl[g][B_EN] && !s_q.ctrl[g][B_DIR] && // RULE_17
				!s_q.ctrl[g][B_OD] && s_q.ctrl[g][B_FN_HI:0] == FN_GPIO |=>
				pad_oe[g] && pad_out[g] == ($past(s_q.lvl[g]) ~^ $past(s_q.ctrl[g][B_POL])))
				else $error("gpio output level or polarity wrong");
			a_aux_in_off: assert property (s_q.ctrl[g][B_EN] && !s_q.ctrl[g][B_DIR] && // RULE_16
				!s_q.ctrl[g][B_OD] && s_q.ctrl[g][B_FN_HI:0] == FN_AUXRST &&
				status.power_state == PWR_OFF |=> pad_out[g] == $past(s_q.ctrl[g][B_POL]))
				else $error("aux reset not asserted in off");
			a_pgood_off: assert property (s_q.ctrl[g][B_FN_HI:0] == FN_PGOOD && // RULE_14
				s_q.ctrl[g][B_POL] && status.power_state == PWR_OFF |=> !pad_out[g])
				else $error("power good shown in off");
			a_edge_flag: assert property (s_in_rise |-> s_q.irq_sts[g]) // RULE_09
				else $error("active edge did not set flag");
			a_rsv_zero: assert property ((s_q.ctrl[g] & ~CTRL_WMASK) == 16'h0000) // RULE_18
				else $error("undefined control bits not zero");
		end
	endgenerate
endmodule : pgpc_top

// ===== pgpc_top_tb.sv
// pgpc_top_tb: self-checking bench for the pin configuration block
`timescale 1ns/10ps
module pgpc_top_tb;
	import pgpc_pkg::*;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic [AW-1:0] addr = '0;
	logic rd_en = 1'b0;
	logic wr_en = 1'b0;
	logic [31:0] wdata = '0;
	logic [31:0] rdata, r;
	logic wreq, irq;
	logic [NPIN-1:0] pad_in, pad_out, pad_oe, pu, pd, lvl;
	logic [NDOM-1:0] ssel;
	logic [NPIN-1:0] ext_en = '0;
	logic [NPIN-1:0] ext_val = '0;
	pgpc_status_s st = '0;
	int fails = 0;
	int total_checks = 0;
	int cyc = 0;
	// 50 MHz clock
	always #10 ref_clk = ~ref_clk;
	pgpc_top u_dut (.ref_clk(ref_clk), .srst(srst), .avs_address(addr), .avs_read(rd_en),
		.avs_write(wr_en), .avs_writedata(wdata), .avs_byteenable(4'hF), .avs_readdata(rdata),
		.avs_waitrequest(wreq), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
		.pull_up_en(pu), .pull_down_en(pd), .supply_sel(ssel), .status(st),
		.pin_in_level(lvl), .irq(irq));
	pgpc_pad_model u_pads (.ref_clk(ref_clk), .pad_out(pad_out), .pad_oe(pad_oe),
		.pull_up_en(pu), .pull_down_en(pd), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
	task print_verdict;
		if (fails == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : print_verdict
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// one avalon cycle, held until waitrequest is sampled low
	task bus(input logic wr, input logic [15:0] idx, input logic [15:0] d);
		@(posedge ref_clk);
		addr <= {idx, 2'b00};
		wr_en <= wr;
		rd_en <= !wr;
		wdata <= {16'h0000, d};
		@(posedge ref_clk iff !wreq);
		r = rdata;
		wr_en <= 1'b0;
		rd_en <= 1'b0;
	endtask : bus
	// look at outputs mid-cycle so edge updates have landed
	task settle(input int n);
		repeat (n) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask : settle
	task t_reset;
		for (int n = 0; n < NPIN; n++)
		begin
			bus(0, IDX_CTRL0 + 16'(n), 0);
			chk("ctrl_rst", r, 32'h0000A400);
		end
		chk("oe_rst", pad_oe, 0);
		chk("pull_rst", {pu, pd}, 0);
		bus(0, 16'h4048, 0);
		chk("unmapped", r, 0);
	endtask : t_reset
	task t_mask;
		bus(1, IDX_CTRL0 + 16'h0001, 16'hFFFF);
		bus(0, IDX_CTRL0 + 16'h0001, 0);
		chk("ctrl_mask", r, 32'h0000FE8F);
		settle(1);
		chk("supply_sel", ssel, 12'h002);
		bus(1, IDX_CTRL0 + 16'h0001, 16'hA400);
	endtask : t_mask
	task t_pulls;
		ext_en[0] <= 1'b1;
		for (int c = 0; c < 4; c++)
		begin
			bus(1, IDX_CTRL0, 16'h8480 | 16'(c << 13));
			settle(1);
			chk("pull_up", pu[0], c == 2);
			chk("pull_down", pd[0], c == 1);
		end
	endtask : t_pulls
	task t_gpio;
		ext_en[0] <= 1'b0;
		for (int p = 0; p < 2; p++)
			for (int v = 0; v < 2; v++)
			begin
				bus(1, IDX_CTRL0, 16'h0080 | 16'(p << 10));
				bus(1, IDX_LEVEL, 16'(v));
				settle(1);
				chk("oe_cmos", pad_oe[0], 1);
				chk("out_lvl", pad_out[0], v[0] ^ !p[0]);
			end
		// open drain with the internal pull-up, no board resistor
		bus(1, IDX_CTRL0, 16'h4680);
		for (int v = 0; v < 2; v++)
		begin
			bus(1, IDX_LEVEL, 16'(v));
			settle(1);
			chk("oe_od", pad_oe[0], !v[0]);
			chk("out_od", pad_out[0], 0);
			chk("pu_od", pu[0], 1);
		end
		bus(1, IDX_CTRL0, 16'h4400);
		settle(1);
		chk("oe_off", {pad_oe[0], pu[0]}, 0);
	endtask : t_gpio
	task t_funcs;
		pgpc_status_s tab [3];
		logic e;
		tab[0] = '{1'b1, 2'b11, 1'b1, 1'b1, 1'b1, PWR_ON};
		tab[1] = '{1'b0, 2'b00, 1'b0, 1'b1, 1'b0, PWR_OFF};
		tab[2] = '{1'b0, 2'b00, 1'b0, 1'b1, 1'b0, PWR_SLEEP};
		for (int p = 0; p < 2; p++)
			for (int f = 9; f < 16; f++)
			begin
				bus(1, IDX_CTRL0, 16'h0080 | 16'(p << 10) | 16'(f));
				for (int s = 0; s < 3; s++)
				begin
					@(posedge ref_clk);
					st <= tab[s];
					settle(1);
					case (f)
						9: e = tab[s].slew_done_dc2;
						10: e = tab[s].ext_enable[0];
						11: e = tab[s].ext_enable[1];
						12: e = tab[s].system_supply_ok;
						13: e = tab[s].converters_power_good && tab[s].power_state != PWR_OFF;
						14: e = tab[s].conv_clk_2mhz;
						default: e = tab[s].power_state == PWR_OFF;
					endcase
					chk("fn_out", pad_out[0], e ^ !p[0]);
				end
			end
		// aux reset asserted in sleep once configured so
		bus(1, IDX_AUX_CFG, 16'h0001);
		bus(1, IDX_CTRL0, 16'h048F);
		settle(1);
		chk("aux_sleep", pad_out[0], 1);
	endtask : t_funcs
	// clear pending flags, move the pad, judge the interrupt line
	task edge_irq(input logic v, input logic ei);
		bus(1, IDX_IRQ_CLR, 16'hFFFF);
		@(posedge ref_clk);
		ext_val[0] <= v;
		settle(4);
		chk("irq", irq, ei);
	endtask : edge_irq
	task t_irq;
		ext_en[0] <= 1'b1;
		bus(1, IDX_IRQ_EN, 16'h0001);
		bus(1, IDX_CTRL0, 16'h8480);
		edge_irq(1, 1);
		chk("in_lvl", lvl[0], 1);
		edge_irq(0, 0);
		bus(1, IDX_CTRL0, 16'h9480);
		edge_irq(1, 1);
		edge_irq(0, 1);
		bus(1, IDX_CTRL0, 16'h8080);
		edge_irq(1, 0);
		edge_irq(0, 1);
		chk("in_inv", lvl[0], 1);
		bus(0, IDX_IRQ_STS, 0);
		chk("irq_sts", r, 32'h00000001);
		bus(0, IDX_LEVEL, 0);
		chk("lvl_read", r, 32'h00000001);
		bus(1, IDX_IRQ_EN, 16'h0000);
		settle(1);
		chk("irq_mask", irq, 0);
		bus(1, IDX_CTRL0, 16'h8000);
		settle(4);
		chk("in_off", lvl[0], 0);
	endtask : t_irq
	// hang guard
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fails++;
			print_verdict;
		end
	end
	initial
	begin
		repeat (20) @(posedge ref_clk);
		srst <= 1'b0;
		t_reset;
		t_mask;
		t_pulls;
		t_gpio;
		t_funcs;
		t_irq;
		print_verdict;
	end
endmodule : pgpc_top_tb
